// >>> src/fanout_cfg_pkg.sv
// shared constants and types for the clock fan-out configuration block
package fanout_cfg_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int          PAIR_COUNT   = 10;
  localparam int          WORD_BITS    = 11;
  localparam logic [3:0]  LAST_BIT_IDX = 4'hA;
  localparam int          STROBE_MAX_MHZ = 100;

  typedef struct packed {
    logic                   sel;
    logic [PAIR_COUNT-1:0]  en;
  } cfg_word_s;

  localparam cfg_word_s   CFG_RESET    = '0;
  localparam logic [3:0]  COUNT_RESET  = 4'h0;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          APB_AW       = 8;
  localparam logic [7:0]  LOCK_OFFSET  = 8'h00;
  localparam logic [7:0]  STAT_OFFSET  = 8'h04;
  localparam int          LOCK_BIT     = 0;
  localparam logic        LOCK_RESET   = 1'b0;
  localparam int          STAT_LOADED  = 11;
  localparam int          STAT_GATE    = 12;
  localparam int          STAT_SHIFT   = 13;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SHIFT  = 3'b001,
    ST_WAIT   = 3'b010,
    ST_LOADED = 3'b100
  } cfg_state_e;

  // synchroniser lane indices
  localparam int SY_STROBE = 0;
  localparam int SY_GATE   = 1;
  localparam int SY_SDATA  = 2;
  localparam int SY_CLK_A  = 3;
  localparam int SY_CLK_B  = 4;
  localparam int SY_LANES  = 5;
  // strobe lane rests high like its pin, so release makes no false edge
  localparam logic [SY_LANES-1:0] SYNC_RESET = 5'h01;
endpackage

// >>> src/clock_fanout_serial_config.sv
// serial configuration, output enable and input select of a 1:10 fan-out
// How it works
// - the selected input clock is copied onto all ten output pairs
// - eleven-bit shift register on strobe feeds eleven-bit control word
// - with gate high each pair follows its own loaded enable bit
// - after loading with gate high the last shifted bit picks the input clock; with gate low the serial input level does
// - with gate low all ten pairs stay enabled
// - eleven bits shift in, the twelfth strobe pulse loads the word
// - first bit enables pair nine, tenth bit pair zero, zero tri-states
// - select bit zero picks clock a, one picks clock b
// - one load per reset; strobe with gate low clears the sequencer, not the lock
`timescale 1ns/100ps
module clock_fanout_serial_config (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          config_serial_strobe,
  input  wire logic                          config_serial_in,
  input  wire logic                          program_gate_level,
  input  wire logic                          input_clock_a,
  input  wire logic                          input_clock_b,
  output logic [fanout_cfg_pkg::PAIR_COUNT-1:0] out_clk_p,
  output logic [fanout_cfg_pkg::PAIR_COUNT-1:0] out_clk_n,
  output logic [fanout_cfg_pkg::PAIR_COUNT-1:0] out_oe_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [fanout_cfg_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr
);
  import fanout_cfg_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SY_LANES-1:0] sync1;
  logic [SY_LANES-1:0] sync2;
  logic                strobe_prev;
  logic                strobe_edge;
  logic                gate_s;
  logic                sdata_s;

  // every configuration pin, input clocks too, is asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1       <= SYNC_RESET;
      sync2       <= SYNC_RESET;
      strobe_prev <= SYNC_RESET[SY_STROBE];
    end else begin
      sync1       <= {input_clock_b, input_clock_a, config_serial_in,
                      program_gate_level, config_serial_strobe};
      sync2       <= sync1;
      strobe_prev <= sync2[SY_STROBE];
    end
  end

  assign strobe_edge = sync2[SY_STROBE] & ~strobe_prev;
  assign gate_s      = sync2[SY_GATE];
  assign sdata_s     = sync2[SY_SDATA];

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic        lock;
  logic        bus_write;
  cfg_word_s   shift_word;
  cfg_word_s   ctrl_word;
  cfg_state_e  state;
  logic [3:0]  bit_count;

  assign bus_write = psel & penable & pready & pwrite;

  // lock stops shifting, but a reset pulse still works
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lock <= LOCK_RESET;
    end else if (bus_write && paddr == LOCK_OFFSET) begin
      lock <= pwdata[LOCK_BIT];
    end
  end

  // answer registered in setup, completes in the first access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      if (psel && !penable) begin
        prdata  <= '0;
        pslverr <= 1'b0;
        case (paddr)
          LOCK_OFFSET: begin
            prdata[LOCK_BIT] <= lock;
          end
          STAT_OFFSET: begin
            prdata[WORD_BITS-1:0] <= ctrl_word;
            prdata[STAT_LOADED]   <= (state == ST_LOADED);
            prdata[STAT_GATE]     <= gate_s;
            prdata[STAT_SHIFT]    <= (state == ST_SHIFT);
            pslverr               <= pwrite;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // shift and load sequencer
  // ---------------------------------------------------------------
  logic reset_pulse;
  logic shift_step;

  assign reset_pulse = strobe_edge & ~gate_s;
  assign shift_step  = strobe_edge & gate_s & ~lock;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || reset_pulse) begin
      state      <= ST_SHIFT;
      bit_count  <= COUNT_RESET;
      shift_word <= CFG_RESET;
      ctrl_word  <= CFG_RESET;
    end else if (shift_step) begin
      case (state)
        ST_SHIFT: begin
          // first bit ends up in bit 0 after eleven shifts
          shift_word <= {sdata_s, shift_word[WORD_BITS-1:1]};
          bit_count  <= bit_count + 4'h1;
          if (bit_count == LAST_BIT_IDX) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          ctrl_word <= shift_word;
          state     <= ST_LOADED;
        end
        ST_LOADED: begin
          // further pulses ignored until reset
          state <= ST_LOADED;
        end
        default: begin
          state <= ST_SHIFT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output pairs
  // ---------------------------------------------------------------
  logic [PAIR_COUNT-1:0] en_rev;
  logic                  pick_b;
  logic                  clk_sel;

  // bit 0 drives pair nine, bit 9 drives pair zero
  for (genvar n = 0; n < PAIR_COUNT; n++) begin : g_rev
    assign en_rev[n] = ctrl_word.en[PAIR_COUNT-1-n];
  end

  assign pick_b  = gate_s ? ctrl_word.sel : sdata_s;
  assign clk_sel = pick_b ? sync2[SY_CLK_B] : sync2[SY_CLK_A];

  // copy is sampled at sys_clk, so only slow input clocks pass cleanly
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_clk_p <= '0;
      out_clk_n <= '1;
      out_oe_n  <= '0;
    end else begin
      out_clk_p <= {PAIR_COUNT{clk_sel}};
      out_clk_n <= {PAIR_COUNT{~clk_sel}};
      out_oe_n  <= gate_s ? ~en_rev : '0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence seq_reset_pulse;
    strobe_edge && !gate_s;
  endsequence

  sequence seq_load_pulse;
    state == ST_WAIT && shift_step;
  endsequence

  AST_RESET_CLEARS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seq_reset_pulse |=> state == ST_SHIFT && ctrl_word == CFG_RESET
                        && shift_word == CFG_RESET && bit_count == COUNT_RESET)
    else $error("reset pulse did not clear the sequencer");

  AST_LOAD_TWELFTH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seq_load_pulse |=> ctrl_word == $past(shift_word) && state == ST_LOADED)
    else $error("twelfth pulse did not load the control word");

  AST_ONE_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == ST_LOADED && !reset_pulse |=> $stable(ctrl_word))
    else $error("control word changed after its single load");

  AST_SHIFT_COUNT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == ST_SHIFT && shift_step && !reset_pulse
      |=> bit_count == $past(bit_count) + 4'h1
          && shift_word.sel == $past(sdata_s))
    else $error("shift step did not advance");

  AST_NO_EARLY_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == ST_SHIFT && !reset_pulse |=> ctrl_word == $past(ctrl_word))
    else $error("control word loaded before eleven bits");

  AST_ALL_ON_STD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !gate_s |=> out_oe_n == '0)
    else $error("pair disabled with gate low");

  AST_PER_PAIR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gate_s |=> out_oe_n == ~$past(en_rev))
    else $error("pair enable does not follow the control word");

  AST_SEL_PROG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gate_s ##0 (ctrl_word.sel ? sync2[SY_CLK_B] : sync2[SY_CLK_A])
      |=> out_clk_p[0])
    else $error("programmed clock choice not followed");

  AST_SEL_STD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !gate_s |=> out_clk_p[0] == $past(sdata_s ? sync2[SY_CLK_B]
                                              : sync2[SY_CLK_A]))
    else $error("serial level clock choice not followed");

  AST_COPY_ALL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 out_clk_p == {PAIR_COUNT{out_clk_p[0]}} && out_clk_n == ~out_clk_p)
    else $error("output pairs disagree");
endmodule

// >>> sim/cfg_host_model.sv
// host controller model driving the serial configuration pins
`timescale 1ns/100ps
module cfg_host_model (
  input  wire logic sys_clk,
  output logic      strobe,
  output logic      si,
  output logic      gate
);
  // strobe idles high (pull-up), data and gate idle low (pull-down)
  initial begin
    strobe = 1'b1;
    si     = 1'b0;
    gate   = 1'b0;
  end
  // 900 ns strobe period, far below the 100 MHz limit
  task automatic pulse(input logic b);
    @(posedge sys_clk);
    si     <= b;
    strobe <= 1'b0;
    repeat (4) @(posedge sys_clk);
    strobe <= 1'b1;
    repeat (4) @(posedge sys_clk);
    si     <= 1'b0;
  endtask
  task automatic set_gate(input logic g);
    @(posedge sys_clk);
    gate <= g;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic set_si(input logic b);
    @(posedge sys_clk);
    si <= b;
  endtask
  // one strobe with gate low clears the sequencer
  task automatic pin_reset();
    set_gate(1'b0);
    pulse(1'b0);
  endtask
  // bit0 first, eleven data edges, then the load edge
  task automatic frame(input logic [10:0] w);
    set_gate(1'b1);
    for (int i = 0; i < 11; i++) begin
      pulse(w[i]);
    end
    pulse(1'b0);
  endtask
endmodule

// >>> sim/clock_fanout_serial_config_tb.sv
// self-checking bench for the fan-out configuration block
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module clock_fanout_serial_config_tb;
  import fanout_cfg_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_a, clk_b, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, strobe, si, gate;
  logic [9:0]  oc_p, oc_n, oe_n;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  cfg_host_model host (.sys_clk(sys_clk), .strobe(strobe), .si(si),
                       .gate(gate));
  clock_fanout_serial_config dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .config_serial_strobe(strobe),
    .config_serial_in(si), .program_gate_level(gate),
    .input_clock_a(clk_a), .input_clock_b(clk_b), .out_clk_p(oc_p),
    .out_clk_n(oc_n), .out_oe_n(oe_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // levels chosen so a and b are told apart; outputs settle in 3 cycles
  task automatic clocks(input logic a, input logic b);
    @(posedge sys_clk);
    clk_a <= a;
    clk_b <= b;
    repeat (8) @(posedge sys_clk);
  endtask
  function automatic logic [9:0] exp_oe(input logic [10:0] w);
    for (int n = 0; n < 10; n++) begin
      exp_oe[n] = ~w[9-n];
    end
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK(oe_n, 10'h000)
    apb(1'b0, STAT_OFFSET, 32'h0);
    `CHK(rd[13:0], 14'h2000)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, STAT_OFFSET, 32'h7FF);
    `CHK(err, 1'b1)
    $display("t_reset done");
  endtask
  task automatic t_standard();
    host.set_si(1'b0);
    clocks(1'b1, 1'b0);
    `CHK({oc_p, oc_n}, {10'h3FF, 10'h000})
    host.set_si(1'b1);
    repeat (8) @(posedge sys_clk);
    `CHK({oc_p, oe_n}, 20'h0)
    host.set_si(1'b0);
    $display("t_standard done");
  endtask
  task automatic t_program();
    host.pin_reset();
    host.frame(11'h4B5);
    clocks(1'b0, 1'b1);
    `CHK(oe_n, exp_oe(11'h4B5))
    `CHK({oc_p, oc_n}, {10'h3FF, 10'h000})
    apb(1'b0, STAT_OFFSET, 32'h0);
    `CHK(rd[11:0], 12'hCB5)
    host.frame(11'h0F0);
    `CHK(oe_n, exp_oe(11'h4B5))
    host.set_gate(1'b0);
    repeat (4) @(posedge sys_clk);
    `CHK(oe_n, 10'h000)
    host.pin_reset();
    apb(1'b0, STAT_OFFSET, 32'h0);
    `CHK(rd[11:0], 12'h000)
    host.frame(11'h2AA);
    repeat (4) @(posedge sys_clk);
    `CHK({oc_p, oc_n, oe_n}, {10'h000, 10'h3FF, exp_oe(11'h2AA)})
    host.pin_reset();
    $display("t_program done");
  endtask
  task automatic t_lock();
    apb(1'b1, LOCK_OFFSET, 32'h1);
    apb(1'b0, LOCK_OFFSET, 32'h0);
    `CHK(rd[0], 1'b1)
    host.frame(11'h3FF);
    apb(1'b0, STAT_OFFSET, 32'h0);
    `CHK(rd[11:0], 12'h000)
    apb(1'b1, LOCK_OFFSET, 32'h0);
    $display("t_lock done");
  endtask
  initial begin
    clk_a   <= 1'b0;
    clk_b   <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_standard();
    t_program();
    t_lock();
    end_sim();
  end
endmodule
